// *** design/cpi_capture.sv ***
module cpi_capture
   import cpi_pkg::*;
(
   // system clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // configuration, system domain, held static while capturing
   input wire cpi_pkg::cpi_fmt_t fmt,
   input wire logic capture_en,
   // sensor link, pixel clock domain
   input wire logic sensor_pixel_clock,
   input wire logic [cpi_pkg::CPI_BUS_W-1:0] cam_data,
   input wire logic frame_sync,
   input wire logic line_sync,
   input wire logic field_in,
   // master clock toward sensor
   output logic sensor_master_clock,
   // pixel stream, pixel clock domain
   output logic pix_valid,
   output logic [cpi_pkg::CPI_PIX_W-1:0] pix_data,
   output logic pix_sof,
   output logic pix_sol,
   output logic pix_field,
   // frame and line events, system domain
   output logic frame_start,
   output logic line_end
);
   import cpi_pkg::*;

   // ****************************************************************
   // master clock divider, system domain
   // ****************************************************************
   logic [3:0] div_reg; // half period counter
   // the sensor's reference clock comes from our own clock, not the link
   // limitation: the reference is a fixed division of clk with half duty,
   // so the sensor sees no glitch when the link clock stops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div_reg <= CPI_DIV_RST;
         sensor_master_clock <= 1'b0;
      end else if (div_reg == CPI_MCLK_HALF - 4'h1) begin
         div_reg <= CPI_DIV_RST;
         sensor_master_clock <= ~sensor_master_clock;
      end else begin
         div_reg <= div_reg + 4'h1;
      end
   end

   // ****************************************************************
   // link reset and configuration crossing
   // ****************************************************************
   logic prst_n;       // reset released in pixel domain
   logic prst_meta_reg; // reset release first stage
   // a stopped pixel clock keeps the link side in reset until it runs,
   // which is harmless since nothing can be captured without it
   // async assert, release synchronised to the pixel clock
   always_ff @(posedge sensor_pixel_clock or negedge rst_n) begin
      if (!rst_n) begin
         prst_meta_reg <= 1'b0;
         prst_n <= 1'b0;
      end else begin
         prst_meta_reg <= 1'b1;
         prst_n <= prst_meta_reg;
      end
   end
   logic [4:0] cfg_sync; // {enable, format} in pixel domain
   cpi_sync2 #(.W(5)) u_cfg_sync (
      .clk(sensor_pixel_clock),
      .rst_n(prst_n),
      .d({capture_en, fmt}),
      .q(cfg_sync)
   );
   logic [4:0] cfg_last_reg; // synced word one pixel clock ago
   logic [4:0] cfg_reg; // word taken once it holds still
   // the bits of the word may land on different edges; only a word seen
   // unchanged on two edges in a row is taken, so no mixed code decodes
   // trade-off: a change takes two more pixel clocks to show
   always_ff @(posedge sensor_pixel_clock or negedge prst_n) begin
      if (!prst_n) begin
         cfg_last_reg <= '0;
         cfg_reg <= '0;
      end else begin
         cfg_last_reg <= cfg_sync;
         if (cfg_sync == cfg_last_reg) begin
            cfg_reg <= cfg_sync; // word settled
         end
      end
   end
   logic en_p;         // enable, pixel domain
   cpi_fmt_t fmt_p;    // format, pixel domain
   assign en_p = cfg_reg[4];
   assign fmt_p = cpi_fmt_t'(cfg_reg[3:0]);

   // ****************************************************************
   // input registers on the pixel clock
   // ****************************************************************
   logic [CPI_BUS_W-1:0] dat_reg; // bus sampled at pixel clock
   logic fs_reg;       // frame sync sample
   logic fs_last_reg;  // previous frame sync
   logic ls_reg;       // line sync sample
   logic ls_last_reg;  // previous line sync
   logic fld_reg;      // field sample
   // pins are sampled on the sensor's own clock, source synchronous
   always_ff @(posedge sensor_pixel_clock or negedge prst_n) begin
      if (!prst_n) begin
         dat_reg <= CPI_PIX_RST;
         fs_reg <= 1'b0;
         fs_last_reg <= 1'b0;
         ls_reg <= 1'b0;
         ls_last_reg <= 1'b0;
         fld_reg <= 1'b0;
      end else begin
         dat_reg <= cam_data;
         fs_reg <= frame_sync;
         fs_last_reg <= fs_reg;
         ls_reg <= line_sync;
         ls_last_reg <= ls_reg;
         fld_reg <= field_in;
      end
   end
   // edges are found from registered copies only, never from the pins,
   // so a sync glitch between two pixel edges goes unseen
   logic fs_rise;  // frame begins
   logic ls_rise;  // line begins
   logic ls_fall;  // line ends
   assign fs_rise = fs_reg & ~fs_last_reg;
   assign ls_rise = ls_reg & ~ls_last_reg;
   assign ls_fall = ~ls_reg & ls_last_reg;

   // ****************************************************************
   // frame state, pixel domain
   // ****************************************************************
   logic in_frame_reg;  // inside an active frame
   logic sof_pend_reg;  // first pixel of frame still to come
   logic sol_pend_reg;  // first pixel of line still to come
   logic pix_step;      // pixel completes this edge
   // a frame only opens on frame sync, so a late enable waits a frame
   // enable low drops the frame at once; beats in flight are discarded
   always_ff @(posedge sensor_pixel_clock or negedge prst_n) begin
      if (!prst_n) begin
         in_frame_reg <= 1'b0;
         sof_pend_reg <= 1'b0;
      end else if (!en_p) begin
         in_frame_reg <= 1'b0;
         sof_pend_reg <= 1'b0;
      end else if (fs_rise) begin
         in_frame_reg <= 1'b1;
         sof_pend_reg <= 1'b1;
      end else if (pix_step) begin
         sof_pend_reg <= 1'b0;
      end
   end
   // a one-beat pixel closes on the very edge that sees the line open,
   // so the opening is also passed straight to the start flag below
   always_ff @(posedge sensor_pixel_clock or negedge prst_n) begin
      if (!prst_n) begin
         sol_pend_reg <= 1'b0;
      end else if (pix_step) begin
         sol_pend_reg <= 1'b0; // opening used by this pixel
      end else if (ls_rise) begin
         sol_pend_reg <= 1'b1;
      end
   end
   logic sample_ok; // a beat is taken
   assign sample_ok = in_frame_reg & ls_reg & en_p;

   // ****************************************************************
   // multi-beat assembly for 8-bit sources
   // ****************************************************************
   logic [1:0] beat_reg;       // beat within the pixel
   logic [15:0] hold_reg;      // earlier beats
   logic [1:0] beats_needed;   // beats per pixel minus one
   logic [7:0] b8;             // 8-bit lane
   assign b8 = dat_reg[CPI_B8_HI:CPI_B8_LO];
   // 8-bit sources spread one pixel over two or three beats; hold keeps
   // the earlier beats and the last one comes straight from the bus
   always_comb begin
      case (fmt_p)
         CPI_FMT_BT656, CPI_FMT_YUV_2CYC: beats_needed = 2'd1;
         CPI_FMT_RGB888_3CYC: beats_needed = 2'd2;
         default: beats_needed = 2'd0;
      endcase
   end
   assign pix_step = sample_ok & (beat_reg == beats_needed);
   // beat counter restarts each line so lines stay aligned
   always_ff @(posedge sensor_pixel_clock or negedge prst_n) begin
      if (!prst_n) begin
         beat_reg <= 2'd0;
         hold_reg <= 16'h0000;
      end else if (!ls_reg) begin
         beat_reg <= 2'd0;
      end else if (sample_ok) begin
         hold_reg <= {hold_reg[7:0], b8};
         beat_reg <= pix_step ? 2'd0 : beat_reg + 2'd1;
      end
   end

   // ****************************************************************
   // lane unpacking per format
   // ****************************************************************
   logic [CPI_PIX_W-1:0] pix_next; // unpacked pixel
   // undecoded format codes give a zero pixel, never stale lanes
   always_comb begin
      pix_next = CPI_PIX_RST;
      case (fmt_p)
         CPI_FMT_BT656, CPI_FMT_YUV_2CYC: begin
            pix_next = {8'h00, hold_reg[7:0], b8};
         end
         CPI_FMT_RGB888_3CYC: begin
            pix_next = {hold_reg, b8};
         end
         CPI_FMT_GENERIC10: begin
            // sample bit n stays at bit n
            pix_next = {14'h0, dat_reg[CPI_B10_HI:0]};
         end
         CPI_FMT_YUV_1CYC: begin
            // luma in the high byte, chroma in the low byte
            pix_next = {8'h00, dat_reg[CPI_B16_HI:0]};
         end
         CPI_FMT_RGB565: begin
            // expand to r,g,b bytes, msb aligned
            pix_next = {dat_reg[CPI_B16_HI:CPI_565_R_LO], 3'h0,
                        dat_reg[CPI_565_R_LO-1:CPI_565_G_LO], 2'h0,
                        dat_reg[CPI_565_G_LO-1:CPI_565_B_LO], 3'h0};
         end
         CPI_FMT_RGB888_1CYC: begin
            // lanes come out as {R,G,B}
            pix_next = {dat_reg[CPI_LANE2_LO+7:CPI_LANE2_LO],
                        dat_reg[CPI_LANE1_LO+7:CPI_LANE1_LO],
                        dat_reg[CPI_LANE0_LO+7:CPI_LANE0_LO]};
         end
         CPI_FMT_TVDEC_1CYC: begin
            // lanes come out as {Y,Cb,Cr}
            pix_next = {dat_reg[CPI_LANE2_LO+7:CPI_LANE2_LO],
                        dat_reg[CPI_LANE1_LO+7:CPI_LANE1_LO],
                        dat_reg[CPI_LANE0_LO+7:CPI_LANE0_LO]};
         end
         default: begin
            pix_next = CPI_PIX_RST;
         end
      endcase
   end

   // ****************************************************************
   // pixel output registers
   // ****************************************************************
   // data and field move only with a pixel, so they hold in between;
   // flags are one pixel clock wide, like the valid strobe
   always_ff @(posedge sensor_pixel_clock or negedge prst_n) begin
      if (!prst_n) begin
         pix_valid <= 1'b0;
         pix_data <= CPI_PIX_RST;
         pix_sof <= 1'b0;
         pix_sol <= 1'b0;
         pix_field <= 1'b0;
      end else begin
         pix_valid <= pix_step;
         pix_sof <= pix_step & sof_pend_reg;
         pix_sol <= pix_step & (sol_pend_reg | ls_rise);
         if (pix_step) begin
            pix_data <= pix_next;
            pix_field <= fld_reg;
         end
      end
   end

   // ****************************************************************
   // events to the system domain
   // ****************************************************************
   // the pixel clock may stop between frames; toggles survive that
   // each event leaves as a one-cycle pulse on clk
   // line ends count only inside a frame; frame start needs the enable
   logic fs_evt;  // frame start, pixel domain
   logic le_evt;  // line end, pixel domain
   assign fs_evt = fs_rise & en_p;
   assign le_evt = ls_fall & in_frame_reg;
   cpi_pulse_xfer u_fs_xfer (
      .src_clk(sensor_pixel_clock),
      .src_rst_n(prst_n),
      .src_pulse(fs_evt),
      .dst_clk(clk),
      .dst_rst_n(rst_n),
      .dst_pulse(frame_start)
   );
   cpi_pulse_xfer u_le_xfer (
      .src_clk(sensor_pixel_clock),
      .src_rst_n(prst_n),
      .src_pulse(le_evt),
      .dst_clk(clk),
      .dst_rst_n(rst_n),
      .dst_pulse(line_end)
   );
endmodule

// *** design/cpi_pkg.sv ***
package cpi_pkg;
   // ****************************************************************
   // bus widths
   // ****************************************************************
   localparam int CPI_BUS_W = 24;        // camera data lines
   localparam int CPI_PIX_W = 24;        // unpacked pixel width
   // ****************************************************************
   // line positions of each source width
   // ****************************************************************
   localparam int CPI_B8_LO = 2;         // 8-bit source lowest line
   localparam int CPI_B8_HI = 9;         // 8-bit source highest line
   localparam int CPI_B10_HI = 9;        // 10-bit source highest line
   localparam int CPI_B16_HI = 15;       // 16-bit source highest line
   // rgb565 fields on the bus
   localparam int CPI_565_B_LO = 0;
   localparam int CPI_565_G_LO = 5;
   localparam int CPI_565_R_LO = 11;
   // one-cycle 24-bit byte lanes
   localparam int CPI_LANE0_LO = 0;
   localparam int CPI_LANE1_LO = 8;
   localparam int CPI_LANE2_LO = 16;
   // ****************************************************************
   // master clock divider and reset values
   // ****************************************************************
   localparam logic [3:0] CPI_MCLK_HALF = 4'h1;  // sys cycles per half period
   localparam logic [3:0] CPI_DIV_RST = 4'h0;
   localparam logic [23:0] CPI_PIX_RST = 24'h000000;
   // ****************************************************************
   // input formats
   // ****************************************************************
   typedef enum logic [3:0] {
      CPI_FMT_BT656,
      CPI_FMT_YUV_2CYC,
      CPI_FMT_RGB888_3CYC,
      CPI_FMT_GENERIC10,
      CPI_FMT_YUV_1CYC,
      CPI_FMT_RGB565,
      CPI_FMT_RGB888_1CYC,
      CPI_FMT_TVDEC_1CYC
   } cpi_fmt_t;
endpackage

// *** design/cpi_sync2.sv ***
// two-flop synchroniser for a level; first stage read only by the second
module cpi_sync2 #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg; // first stage
   // ****************************************************************
   // two stages
   // ****************************************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         q <= '0;
      end else begin
         meta_reg <= d;
         q <= meta_reg;
      end
   end
endmodule

// *** design/cpi_pulse_xfer.sv ***
// moves a one-cycle event across clocks by a toggle
module cpi_pulse_xfer (
   // source side
   input wire logic src_clk,
   input wire logic src_rst_n,
   input wire logic src_pulse,
   // destination side
   input wire logic dst_clk,
   input wire logic dst_rst_n,
   output logic dst_pulse
);
   logic tog_reg;     // flips per event
   logic tog_sync;    // toggle in dst domain
   logic tog_last_reg; // previous synced value
   // ****************************************************************
   // source toggle
   // ****************************************************************
   always_ff @(posedge src_clk or negedge src_rst_n) begin
      if (!src_rst_n) begin
         tog_reg <= 1'b0;
      end else if (src_pulse) begin
         tog_reg <= ~tog_reg;
      end
   end
   cpi_sync2 #(.W(1)) u_sync (
      .clk(dst_clk),
      .rst_n(dst_rst_n),
      .d(tog_reg),
      .q(tog_sync)
   );
   // ****************************************************************
   // edge of the synced toggle
   // ****************************************************************
   always_ff @(posedge dst_clk or negedge dst_rst_n) begin
      if (!dst_rst_n) begin
         tog_last_reg <= 1'b0;
         dst_pulse <= 1'b0;
      end else begin
         tog_last_reg <= tog_sync;
         dst_pulse <= tog_sync ^ tog_last_reg;
      end
   end
endmodule

// *** bench/cpi_capture_props.sv ***
module cpi_capture_props
   import cpi_pkg::*;
(
   // system side
   input wire logic clk,
   input wire logic rst_n,
   input wire cpi_pkg::cpi_fmt_t fmt,
   input wire logic capture_en,
   // link side
   input wire logic sensor_pixel_clock,
   input wire logic [cpi_pkg::CPI_BUS_W-1:0] cam_data,
   input wire logic frame_sync,
   input wire logic line_sync,
   input wire logic field_in,
   // watched outputs
   input wire logic sensor_master_clock,
   input wire logic pix_valid,
   input wire logic [cpi_pkg::CPI_PIX_W-1:0] pix_data,
   input wire logic pix_sof,
   input wire logic pix_sol,
   input wire logic pix_field,
   input wire logic frame_start,
   input wire logic line_end
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // beat history: q2 holds the beat that closed the pixel now shown
   // ****
   logic [23:0] q1_reg, q2_reg, q3_reg, q4_reg;
   always_ff @(posedge sensor_pixel_clock or negedge rst_n) begin
      if (!rst_n) begin
         q1_reg <= 24'h000000;
         q2_reg <= 24'h000000;
         q3_reg <= 24'h000000;
         q4_reg <= 24'h000000;
      end else begin
         q1_reg <= cam_data;
         q2_reg <= q1_reg;
         q3_reg <= q2_reg;
         q4_reg <= q3_reg;
      end
   end
   // ****
   // lane mapping, one per format, except CPI_FMT_BT656 and CPI_FMT_YUV_2CYC which share byte_pair_a
   // ****
   tvdec_lanes_a: assert property (@(posedge sensor_pixel_clock) disable iff (!rst_n)
      pix_valid && fmt == CPI_FMT_TVDEC_1CYC |-> pix_data == $past(cam_data, 2)) else $error("tv pixel wrong");
   rgb888_lanes_a: assert property (@(posedge sensor_pixel_clock) disable iff (!rst_n)
      pix_valid && fmt == CPI_FMT_RGB888_1CYC |-> pix_data == q2_reg) else $error("rgb888 pixel wrong");
   generic_bits_a: assert property (@(posedge sensor_pixel_clock) disable iff (!rst_n)
      pix_valid && fmt == CPI_FMT_GENERIC10 |-> pix_data == (q2_reg & 24'h0003FF)) else $error("10-bit wrong");
   rgb565_fields_a: assert property (@(posedge sensor_pixel_clock) disable iff (!rst_n)
      pix_valid && fmt == CPI_FMT_RGB565 |-> pix_data == {q2_reg[15:11], 3'h0, q2_reg[10:5], 2'h0, q2_reg[4:0], 3'h0})
      else $error("rgb565 wrong");
   yuv_one_a: assert property (@(posedge sensor_pixel_clock) disable iff (!rst_n)
      pix_valid && fmt == CPI_FMT_YUV_1CYC |-> pix_data == {8'h00, q2_reg[15:0]}) else $error("yuv wrong");
   byte_pair_a: assert property (@(posedge sensor_pixel_clock) disable iff (!rst_n)
      pix_valid && fmt <= CPI_FMT_YUV_2CYC |-> pix_data == {8'h00, q3_reg[9:2], q2_reg[9:2]}) else $error("pair wrong");
   byte_triple_a: assert property (@(posedge sensor_pixel_clock) disable iff (!rst_n)
      pix_valid && fmt == CPI_FMT_RGB888_3CYC |-> pix_data == {q4_reg[9:2], q3_reg[9:2], q2_reg[9:2]})
      else $error("triple wrong");
   // ****
   // framing
   // ****
   line_gate_a: assert property (@(posedge sensor_pixel_clock) disable iff (!rst_n)
      pix_valid |-> $past(line_sync, 2)) else $error("pixel outside line");
   frame_mark_a: assert property (@(posedge sensor_pixel_clock) disable iff (!rst_n)
      pix_sof |-> pix_valid && pix_sol) else $error("frame start flag alone");
   line_start_a: assert property (@(posedge sensor_pixel_clock) disable iff (!rst_n)
      pix_sol |-> pix_valid ##1 !pix_sol) else $error("line start flag wrong");
   // master clock halves every system cycle; first edge out of reset is skipped
   master_toggle_a: assert property (@(posedge clk) disable iff (!rst_n)
      $past(rst_n) |-> sensor_master_clock != $past(sensor_master_clock)) else $error("master clock stuck");
   event_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
      frame_start || line_end |=> !frame_start && !line_end) else $error("event longer than one cycle");
   // main scenarios
   sof_seen_c: cover property (@(posedge sensor_pixel_clock) disable iff (!rst_n) pix_sof);
   triple_seen_c: cover property (@(posedge sensor_pixel_clock) disable iff (!rst_n)
      pix_valid && fmt == CPI_FMT_RGB888_3CYC);
   line_end_c: cover property (@(posedge clk) disable iff (!rst_n) line_end);
endmodule

bind cpi_capture cpi_capture_props u_props (.clk, .rst_n, .fmt, .capture_en, .sensor_pixel_clock, .cam_data,
   .frame_sync, .line_sync, .field_in, .sensor_master_clock, .pix_valid, .pix_data, .pix_sof, .pix_sol,
   .pix_field, .frame_start, .line_end);

// *** bench/cpi_sensor_model.sv ***
module cpi_sensor_model (
   // clock gate from the bench
   input wire logic run,
   // link toward the capture port
   output logic sensor_pixel_clock,
   output logic [23:0] cam_data,
   output logic frame_sync,
   output logic line_sync,
   output logic field_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****
   // pixel clock, parked low while the gate is shut
   // ****
   initial begin
      sensor_pixel_clock = 1'b0;
      cam_data = 24'h000000;
      frame_sync = 1'b0;
      line_sync = 1'b0;
      field_in = 1'b0;
      #7;
      forever #80 sensor_pixel_clock = run & ~sensor_pixel_clock;
   end
   // one beat, changed after the falling edge; idle lines toggle so no stale value survives
   task automatic beat(input logic [23:0] d, input logic fs, input logic ls, input logic f);
      @(negedge sensor_pixel_clock);
      frame_sync = fs;
      line_sync = ls;
      field_in = f;
      cam_data = ls ? d : ~cam_data;
   endtask
endmodule

// *** bench/tb_camera_sensor_parallel_input.sv ***
module tb_camera_sensor_parallel_input;
   timeunit 1ns;
   timeprecision 1ps;
   import cpi_pkg::*;
   // ****
   // signals and bookkeeping
   // ****
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   cpi_fmt_t fmt = CPI_FMT_BT656;
   logic capture_en = 1'b0;
   logic run = 1'b1; // pixel clock gate
   logic sensor_pixel_clock, frame_sync, line_sync, field_in;
   logic [23:0] cam_data, pix_data;
   logic sensor_master_clock, pix_valid, pix_sof, pix_sol, pix_field, frame_start, line_end;
   logic [26:0] exp_q[$]; // field, sof, sol, pixel
   logic [31:0] lfsr = 32'hE92D32F7;
   int miscompares = 0;
   int comparisons = 0;
   int got_fs = 0, got_le = 0, exp_fs = 0, exp_le = 0;
   always #20 clk = ~clk;
   cpi_sensor_model m (.run, .sensor_pixel_clock, .cam_data, .frame_sync, .line_sync, .field_in);
   cpi_capture dut (.clk, .rst_n, .fmt, .capture_en, .sensor_pixel_clock, .cam_data, .frame_sync, .line_sync,
      .field_in, .sensor_master_clock, .pix_valid, .pix_data, .pix_sof, .pix_sol, .pix_field, .frame_start,
      .line_end);
   // ****
   // helpers
   // ****
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [23:0] exp_pix(input cpi_fmt_t f, input logic [23:0] b0, b1, b2);
      case (f)
         CPI_FMT_BT656, CPI_FMT_YUV_2CYC: return {8'h00, b0[9:2], b1[9:2]};
         CPI_FMT_RGB888_3CYC: return {b0[9:2], b1[9:2], b2[9:2]};
         CPI_FMT_GENERIC10: return {14'h0, b0[9:0]};
         CPI_FMT_YUV_1CYC: return {8'h00, b0[15:0]};
         CPI_FMT_RGB565: return {b0[15:11], 3'h0, b0[10:5], 2'h0, b0[4:0], 3'h0};
         default: return b0;
      endcase
   endfunction
   task automatic report(input string what);
      miscompares++;
      $display("unexpected at %0t: %s", $time, what);
   endtask
   task automatic chk_pix(input logic [26:0] got);
      comparisons++;
      if (exp_q.size() == 0) report("pixel with none pending");
      else if (got !== exp_q.pop_front()) report("pixel or flags differ");
   endtask
   task automatic chk_cnt(input int got, input int want);
      comparisons++;
      if (got != want) report("count differs");
   endtask
   task automatic finish_test();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ****
   // watchers: read mid-cycle, after the rising edge updates land
   // ****
   always @(negedge sensor_pixel_clock) begin
      if (pix_valid === 1'b1) chk_pix({pix_field, pix_sof, pix_sol, pix_data});
   end
   always @(negedge clk) begin
      got_fs += (frame_start === 1'b1);
      got_le += (line_end === 1'b1);
   end
   // one frame of two 7-beat lines; in two- and three-beat formats the last beat is a partial pixel that must be dropped
   task automatic run_frame(input cpi_fmt_t f, input logic en);
      int bpp;
      logic [23:0] b[3];
      logic [23:0] d;
      logic sof;
      bpp = (f == CPI_FMT_RGB888_3CYC) ? 3 : (f <= CPI_FMT_YUV_2CYC) ? 2 : 1;
      @(negedge clk);
      fmt = f;
      capture_en = en;
      run = 1'b1;
      repeat (6) m.beat(24'h000000, 1'b0, 1'b0, 1'b0);
      m.beat(24'h000000, 1'b1, 1'b0, 1'b0);
      sof = en;
      repeat (2) begin
         for (int k = 0; k < 7; k++) begin
            lfsr = next_rand(lfsr);
            d = lfsr[23:0];
            b[k % bpp] = d;
            if (en && k % bpp == bpp - 1) begin
               exp_q.push_back({lfsr[24], sof, k == bpp - 1, exp_pix(f, b[0], b[1], b[2])});
               sof = 1'b0;
            end
            m.beat(d, 1'b0, 1'b1, lfsr[24]);
         end
         m.beat(24'h000000, 1'b0, 1'b0, 1'b0);
         exp_le += en;
      end
      exp_fs += en;
      repeat (8) m.beat(24'h000000, 1'b0, 1'b0, 1'b0);
      run = 1'b0;
      chk_cnt(exp_q.size(), 0);
      chk_cnt(got_fs, exp_fs);
      chk_cnt(got_le, exp_le);
      $display("test format %0d enable %0d done", f, en);
   endtask
   // ****
   // main sequence
   // ****
   initial begin
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      for (int i = 0; i < 8; i++) run_frame(cpi_fmt_t'(i), 1'b1);
      run = 1'b1;
      rst_n = 1'b0;
      repeat (16) @(negedge clk);
      chk_cnt({sensor_master_clock, pix_valid, pix_sof, pix_sol, pix_field, frame_start, line_end, pix_data}
         === 31'h0, 1);
      rst_n = 1'b1;
      $display("test reset done");
      run_frame(CPI_FMT_TVDEC_1CYC, 1'b0);
      run_frame(CPI_FMT_RGB565, 1'b1);
      finish_test();
   end
   initial begin
      #1ms;
      report("run did not finish");
      finish_test();
   end
endmodule
